/* verilog/sbm_defines.svh */
// constants for the shunt and bus measurement sequencer
`ifndef SBM_DEFINES_SVH
`define SBM_DEFINES_SVH

// timing: 10 MHz clock, 40 ms recovery after power-down
`define SBM_CLK_HZ        32'h00989680
`define SBM_MS_PER_S      32'h000003e8
`define SBM_PD_RECOVER_MS 32'h00000028

// register pointer values
`define SBM_REG_CONFIG  8'h00
`define SBM_REG_SHUNT   8'h01
`define SBM_REG_BUS     8'h02
`define SBM_REG_POWER   8'h03
`define SBM_REG_CURRENT 8'h04
`define SBM_REG_CALIB   8'h05
`define SBM_REG_MASK    8'h06
`define SBM_REG_LIMIT   8'h07

// configuration fields
`define SBM_CONFIG_RESET 16'h0007
`define SBM_CFG_MODE_HI  2
`define SBM_CFG_MODE_LO  0
`define SBM_CFG_SH_BIT   0
`define SBM_CFG_BUS_BIT  1
`define SBM_CFG_CONT_BIT 2
`define SBM_CFG_AVG_HI   11
`define SBM_CFG_AVG_LO   9
`define SBM_MODE_CONT    3'h7

// averaging: shift per code, nibble per code, code 0 lowest
`define SBM_AVG_SHIFTS   32'ha9876420

// alert select and flags register
`define SBM_MASK_RESET   16'h0000
`define SBM_MASK_WMASK   16'hfc03
`define SBM_ME_FUNC_HI   15
`define SBM_ME_FUNC_LO   11
`define SBM_ME_RDY_ALERT 10
`define SBM_ME_ALERT_FLG 4
`define SBM_ME_READY     3
`define SBM_ME_POLARITY  1
`define SBM_ME_LATCH     0

// function enable positions inside the five-bit select
`define SBM_FN_SH_OVER   4
`define SBM_FN_SH_UNDER  3
`define SBM_FN_BUS_OVER  2
`define SBM_FN_BUS_UNDER 1
`define SBM_FN_PWR_OVER  0

// arithmetic
`define SBM_ACC_W        26
`define SBM_CUR_SHIFT    11
`define SBM_PWR_DIV      32'h00004e20
`define SBM_PWR_MAX      32'h0000ffff

`endif

/* verilog/sbm_pkg.sv */
// types and shared helpers of the measurement sequencer
`default_nettype none
`include "sbm_defines.svh"

package sbm_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAKE,
		ST_SH_WAIT,
		ST_BUS_WAIT
	} sbm_state_type;

	typedef struct packed {
		sbm_state_type          state;
		logic [15:0]            cfg;
		logic [15:0]            calib;
		logic                   cal_set;
		logic [15:0]            mask;
		logic [15:0]            limit;
		logic [15:0]            o_sh;
		logic [15:0]            o_bus;
		logic [15:0]            o_cur;
		logic [15:0]            o_pow;
		logic [`SBM_ACC_W-1:0]  acc_sh;
		logic [`SBM_ACC_W-1:0]  acc_bus;
		logic [`SBM_ACC_W-1:0]  acc_cur;
		logic [`SBM_ACC_W-1:0]  acc_pow;
		logic [10:0]            cnt;
		logic                   pend;
		logic                   ready;
		logic [18:0]            wake;
		logic                   adc_start;
		logic                   adc_bus;
		logic                   pd;
		logic [15:0]            rdata;
		logic                   rvalid;
	} sbm_seq_type;

	typedef struct packed {
		logic [15:0] cur;
		logic        cur_v;
		logic [15:0] pow;
		logic        pow_v;
	} sbm_calc_type;

	typedef struct packed {
		logic aff;
		logic oe;
	} sbm_alert_type;

	function automatic logic [3:0] avg_shift(input logic [2:0] code);
		logic [31:0] lut;
		lut = `SBM_AVG_SHIFTS;
		return lut[{code, 2'b00} +: 4];
	endfunction

	function automatic logic [10:0] avg_last(input logic [2:0] code);
		logic [10:0] one;
		one = 11'h001;
		return (one << avg_shift(code)) - one;
	endfunction

	function automatic logic [`SBM_ACC_W-1:0] sext(input logic [15:0] d,
		input logic sgn);
		return {{(`SBM_ACC_W-16){sgn & d[15]}}, d};
	endfunction

	function automatic logic [15:0] avg_out(
		input logic [`SBM_ACC_W-1:0] sum, input logic [2:0] code,
		input logic sgn);
		logic [`SBM_ACC_W-1:0] r;
		if (sgn) begin
			r = $signed(sum) >>> avg_shift(code);
		end else begin
			r = sum >> avg_shift(code);
		end
		return r[15:0];
	endfunction

endpackage
`default_nettype wire

/* verilog/sbm_calc.sv */
// background current and power arithmetic, one cycle after each sample
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defines.svh"

module sbm_calc import sbm_pkg::*; (
	// clock and control
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// samples
	input  wire logic        sh_valid,
	input  wire logic [15:0] sh_data,
	input  wire logic        bus_valid,
	input  wire logic [15:0] bus_data,
	// calibration
	input  wire logic [15:0] calib,
	input  wire logic        cal_set,
	// results
	output logic             cur_valid,
	output logic [15:0]      cur,
	output logic             pow_valid,
	output logic [15:0]      pow
);

	sbm_calc_type s_q;
	sbm_calc_type n;
	logic signed [32:0] prod_c;
	logic signed [32:0] cur_full;
	logic [15:0]        mag;
	logic [31:0]        prod_p;
	logic [31:0]        quo;

	always_comb begin
		n = s_q;
		n.cur_v = sh_valid;
		n.pow_v = bus_valid;
		prod_c = $signed(sh_data) * $signed({1'b0, calib});
		cur_full = prod_c >>> `SBM_CUR_SHIFT;
		mag = s_q.cur[15] ? (16'h0000 - s_q.cur) : s_q.cur;
		prod_p = mag * bus_data;
		quo = prod_p / `SBM_PWR_DIV;
		if (sh_valid) begin
			n.cur = cal_set ? cur_full[15:0] : 16'h0000;
		end
		// power saturates rather than wrapping
		if (bus_valid) begin
			if (!cal_set) begin
				n.pow = 16'h0000;
			end else if (quo > `SBM_PWR_MAX) begin
				n.pow = 16'hffff;
			end else begin
				n.pow = quo[15:0];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= n;
		end
	end

	assign cur_valid = s_q.cur_v;
	assign cur = s_q.cur;
	assign pow_valid = s_q.pow_v;
	assign pow = s_q.pow;

	cur_next_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && sh_valid |=> cur_valid && ($past(cal_set) || cur == 16'h0000))
		else $error("current result late");
	cal_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && bus_valid && !cal_set |=> pow_valid && pow == 16'h0000)
		else $error("power not zero without calibration");

endmodule
`default_nettype wire

/* verilog/sbm_alert.sv */
// limit comparison and open-drain alert drive
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defines.svh"

module sbm_alert import sbm_pkg::*; (
	// clock and control
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// settings
	input  wire logic [4:0]  func_en,
	input  wire logic        latch_en,
	input  wire logic        polarity,
	input  wire logic        ready_alert_en,
	input  wire logic        ready,
	input  wire logic [15:0] limit,
	// samples
	input  wire logic        sh_valid,
	input  wire logic [15:0] sh_data,
	input  wire logic        bus_valid,
	input  wire logic [15:0] bus_data,
	input  wire logic        pow_valid,
	input  wire logic [15:0] pow_data,
	// flag clear
	input  wire logic        clear,
	// outputs
	output logic             alert_function_flag,
	output logic             alert_oe
);

	sbm_alert_type s_q;
	sbm_alert_type n;
	logic          ev;
	logic          exc;

	// highest enabled function wins, lower enables are ignored
	always_comb begin
		ev = 1'b0;
		exc = 1'b0;
		if (func_en[`SBM_FN_SH_OVER]) begin
			ev = sh_valid;
			exc = $signed(sh_data) > $signed(limit);
		end else if (func_en[`SBM_FN_SH_UNDER]) begin
			ev = sh_valid;
			exc = $signed(sh_data) < $signed(limit);
		end else if (func_en[`SBM_FN_BUS_OVER]) begin
			ev = bus_valid;
			exc = bus_data > limit;
		end else if (func_en[`SBM_FN_BUS_UNDER]) begin
			ev = bus_valid;
			exc = bus_data < limit;
		end else if (func_en[`SBM_FN_PWR_OVER]) begin
			ev = pow_valid;
			exc = pow_data > limit;
		end
	end

	always_comb begin
		n = s_q;
		if (latch_en) begin
			n.aff = (s_q.aff & !clear) | (ev & exc);
		end else if (ev) begin
			n.aff = exc;
		end else begin
			n.aff = s_q.aff & !clear;
		end
		n.oe = (n.aff | (ready_alert_en & ready)) ^ polarity;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= n;
		end
	end

	assign alert_function_flag = s_q.aff;
	assign alert_oe = s_q.oe;

	latch_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && latch_en && s_q.aff && !clear |=> alert_function_flag)
		else $error("latched alert flag dropped");
	prio_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && func_en[`SBM_FN_SH_OVER] && !latch_en && sh_valid
		&& $signed(sh_data) <= $signed(limit) |=> !alert_function_flag)
		else $error("lower priority function acted");
	shunt_over_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && func_en[`SBM_FN_SH_OVER] && sh_valid
		&& $signed(sh_data) > $signed(limit)
		|=> alert_function_flag ##0 (alert_oe == !$past(polarity)))
		else $error("shunt over limit missed");

endmodule
`default_nettype wire

/* verilog/sbm_top.sv */
// measurement sequencer, averaging, register file and alert of the monitor
// Operation
// - continuous mode repeats shunt then bus conversions without host action
// - current follows each shunt sample, power follows each bus sample
// - current and power read zero until calibration is written
// - samples add into accumulators until the averaging count is reached
// - averaged results load together and hold until the next full cycle
// - register reads never disturb or delay a conversion
// - mode codes select shunt only, bus only, or both channels
// - arithmetic runs beside conversions, adding no conversion time
// - a single-shot code runs the averaging count of measurement sets, then stops
// - every configuration write retriggers single-shot, even unchanged
// - power-down keeps registers alive, idles, device waits recovery time before restarting
// - ready flag sets only after a whole cycle is finished
// - ready clears on configuration write (not power-down) or mask read
// - one limit register holds the threshold of the one chosen function
// - with several enables, only the highest enable bit is monitored
// - open-drain alert level follows the polarity bit when flag is set
// - shunt functions compare each shunt sample and set the flag
// - bus functions compare each bus sample, flag and pin assert
// - power function compares each computed power, flag and pin assert
// - latched flag and pin hold until configuration write or mask read
// - comparisons use raw per-sample values, not averages
`timescale 1ns/1ps
`default_nettype none
`include "sbm_defines.svh"

module sbm_top import sbm_pkg::*; #(
	parameter logic [18:0] RECOVER_CYCLES = 19'(`SBM_PD_RECOVER_MS
		* (`SBM_CLK_HZ / `SBM_MS_PER_S))
) (
	// clock, reset, enable
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic [15:0]      reg_rdata,
	output logic             reg_rvalid,
	// converter
	output logic             adc_start,
	output logic             adc_sel_bus,
	output logic             adc_power_down,
	input  wire logic        adc_done,
	input  wire logic [15:0] adc_data,
	// alert pin, open drain
	input  wire logic        alert_in,
	output logic             alert_out,
	output logic             alert_oe
);

	localparam sbm_seq_type SEQ_RESET = '{state: ST_WAKE,
		cfg: `SBM_CONFIG_RESET, mask: `SBM_MASK_RESET, default: '0};

	sbm_seq_type s_q;
	sbm_seq_type n;
	logic [2:0]  mode;
	logic [2:0]  nmode;
	logic [2:0]  avg;
	logic        cfg_wr;
	logic        mask_rd;
	logic        wr_pd;
	logic        old_pd;
	logic        last;
	logic        sh_done;
	logic        bus_done;
	logic        set_end;
	logic        fin;
	logic        go_sh;
	logic        go_bus;
	logic        cur_valid;
	logic [15:0] cur;
	logic        pow_valid;
	logic [15:0] pow;
	logic        alert_function_flag;

	always_comb begin
		n = s_q;
		n.adc_start = 1'b0;
		n.rvalid = 1'b0;
		go_sh = 1'b0;
		go_bus = 1'b0;
		mode = s_q.cfg[`SBM_CFG_MODE_HI:`SBM_CFG_MODE_LO];
		nmode = reg_wdata[`SBM_CFG_MODE_HI:`SBM_CFG_MODE_LO];
		avg = s_q.cfg[`SBM_CFG_AVG_HI:`SBM_CFG_AVG_LO];
		cfg_wr = reg_wr && (reg_addr == `SBM_REG_CONFIG);
		mask_rd = reg_rd && (reg_addr == `SBM_REG_MASK);
		wr_pd = !nmode[`SBM_CFG_SH_BIT] && !nmode[`SBM_CFG_BUS_BIT];
		old_pd = !mode[`SBM_CFG_SH_BIT] && !mode[`SBM_CFG_BUS_BIT];
		last = (s_q.cnt == avg_last(avg));
		sh_done = adc_done && (s_q.state == ST_SH_WAIT);
		bus_done = adc_done && (s_q.state == ST_BUS_WAIT);
		set_end = (sh_done && !mode[`SBM_CFG_BUS_BIT]) || bus_done;
		// the averaging cycle ends on its last channel's arithmetic result
		fin = s_q.pend && (mode[`SBM_CFG_BUS_BIT] ? pow_valid : cur_valid);

		if (reg_wr) begin
			case (reg_addr)
			`SBM_REG_CONFIG: n.cfg = reg_wdata;
			`SBM_REG_CALIB: begin
				n.calib = reg_wdata;
				n.cal_set = 1'b1;
			end
			`SBM_REG_MASK: n.mask = reg_wdata & `SBM_MASK_WMASK;
			`SBM_REG_LIMIT: n.limit = reg_wdata;
			default: ;
			endcase
		end

		// reads sample state, a mask read also clears ready and the alert flag, sequencing never looks at them
		if (reg_rd) begin
			n.rvalid = 1'b1;
			case (reg_addr)
			`SBM_REG_CONFIG: n.rdata = s_q.cfg;
			`SBM_REG_SHUNT: n.rdata = s_q.o_sh;
			`SBM_REG_BUS: n.rdata = s_q.o_bus;
			`SBM_REG_POWER: n.rdata = s_q.o_pow;
			`SBM_REG_CURRENT: n.rdata = s_q.o_cur;
			`SBM_REG_CALIB: n.rdata = s_q.calib;
			`SBM_REG_MASK: begin
				n.rdata = s_q.mask;
				n.rdata[`SBM_ME_ALERT_FLG] = alert_function_flag;
				n.rdata[`SBM_ME_READY] = s_q.ready;
			end
			`SBM_REG_LIMIT: n.rdata = s_q.limit;
			default: n.rdata = 16'h0000;
			endcase
		end

		if (sh_done) begin
			n.acc_sh = s_q.acc_sh + sext(adc_data, 1'b1);
		end
		if (bus_done) begin
			n.acc_bus = s_q.acc_bus + sext(adc_data, 1'b0);
		end
		if (cur_valid) begin
			n.acc_cur = s_q.acc_cur + sext(cur, 1'b1);
		end
		if (pow_valid) begin
			n.acc_pow = s_q.acc_pow + sext(pow, 1'b0);
		end
		if (set_end) begin
			if (last) begin
				n.pend = 1'b1;
				n.cnt = 11'h000;
			end else begin
				n.cnt = s_q.cnt + 11'h001;
			end
		end

		// next conversion starts at once, arithmetic trails in background
		case (s_q.state)
		ST_WAKE: begin
			if (s_q.wake == 19'h00000) begin
				go_sh = mode[`SBM_CFG_SH_BIT];
				go_bus = !mode[`SBM_CFG_SH_BIT];
			end else begin
				n.wake = s_q.wake - 19'h00001;
			end
		end
		ST_SH_WAIT: begin
			if (sh_done) begin
				if (mode[`SBM_CFG_BUS_BIT]) begin
					go_bus = 1'b1;
				end else if (!last || mode[`SBM_CFG_CONT_BIT]) begin
					go_sh = 1'b1;
				end else begin
					n.state = ST_IDLE;
				end
			end
		end
		ST_BUS_WAIT: begin
			if (bus_done) begin
				if (last && !mode[`SBM_CFG_CONT_BIT]) begin
					n.state = ST_IDLE;
				end else if (mode[`SBM_CFG_SH_BIT]) begin
					go_sh = 1'b1;
				end else begin
					go_bus = 1'b1;
				end
			end
		end
		default: ;
		endcase

		if ((cfg_wr && !wr_pd) || mask_rd) begin
			n.ready = 1'b0;
		end
		if (fin) begin
			if (mode[`SBM_CFG_SH_BIT]) begin
				n.o_sh = avg_out(n.acc_sh, avg, 1'b1);
				n.o_cur = avg_out(n.acc_cur, avg, 1'b1);
			end
			if (mode[`SBM_CFG_BUS_BIT]) begin
				n.o_bus = avg_out(n.acc_bus, avg, 1'b0);
				n.o_pow = avg_out(n.acc_pow, avg, 1'b0);
			end
			n.acc_sh = '0;
			n.acc_bus = '0;
			n.acc_cur = '0;
			n.acc_pow = '0;
			n.pend = 1'b0;
			n.ready = 1'b1;
		end

		// any configuration write that is not power-down restarts, same mode included
		if (cfg_wr) begin
			n.cnt = 11'h000;
			n.pend = 1'b0;
			n.acc_sh = '0;
			n.acc_bus = '0;
			n.acc_cur = '0;
			n.acc_pow = '0;
			go_sh = 1'b0;
			go_bus = 1'b0;
			n.state = ST_IDLE;
			if (!wr_pd) begin
				if (old_pd) begin
					n.state = ST_WAKE;
					n.wake = RECOVER_CYCLES;
				end else begin
					go_sh = nmode[`SBM_CFG_SH_BIT];
					go_bus = !nmode[`SBM_CFG_SH_BIT];
				end
			end
		end

		if (go_sh) begin
			n.state = ST_SH_WAIT;
			n.adc_start = 1'b1;
			n.adc_bus = 1'b0;
		end else if (go_bus) begin
			n.state = ST_BUS_WAIT;
			n.adc_start = 1'b1;
			n.adc_bus = 1'b1;
		end
		n.pd = (n.state == ST_IDLE) && !n.cfg[`SBM_CFG_SH_BIT]
			&& !n.cfg[`SBM_CFG_BUS_BIT];
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= SEQ_RESET;
		end else if (ce) begin
			s_q <= n;
		end
	end

	sbm_calc u_calc (
		.clock     (clock),
		.rst_n     (rst_n),
		.ce        (ce),
		.sh_valid  (sh_done),
		.sh_data   (adc_data),
		.bus_valid (bus_done),
		.bus_data  (adc_data),
		.calib     (s_q.calib),
		.cal_set   (s_q.cal_set),
		.cur_valid (cur_valid),
		.cur       (cur),
		.pow_valid (pow_valid),
		.pow       (pow)
	);

	// flags clear on config write or mask read, a new excess still wins
	sbm_alert u_alert (
		.clock               (clock),
		.rst_n               (rst_n),
		.ce                  (ce),
		.func_en             (s_q.mask[`SBM_ME_FUNC_HI:`SBM_ME_FUNC_LO]),
		.latch_en            (s_q.mask[`SBM_ME_LATCH]),
		.polarity            (s_q.mask[`SBM_ME_POLARITY]),
		.ready_alert_en      (s_q.mask[`SBM_ME_RDY_ALERT]),
		.ready               (s_q.ready),
		.limit               (s_q.limit),
		.sh_valid            (sh_done),
		.sh_data             (adc_data),
		.bus_valid           (bus_done),
		.bus_data            (adc_data),
		.pow_valid           (pow_valid),
		.pow_data            (pow),
		.clear               (cfg_wr || mask_rd),
		.alert_function_flag (alert_function_flag),
		.alert_oe            (alert_oe)
	);

	// pin level is not needed, the device only pulls low
	assign alert_out = 1'b0;
	assign reg_rdata = s_q.rdata;
	assign reg_rvalid = s_q.rvalid;
	assign adc_start = s_q.adc_start;
	assign adc_sel_bus = s_q.adc_bus;
	assign adc_power_down = s_q.pd;

	ready_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && fin |=> s_q.ready)
		else $error("ready flag not set after cycle");
	ready_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && mask_rd && !fin |=> !s_q.ready)
		else $error("ready flag not cleared by mask read");
	ready_pd_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && cfg_wr && wr_pd && !mask_rd && s_q.ready |=> s_q.ready)
		else $error("power-down write cleared ready flag");
	out_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
		!(ce && fin) |=> $stable(s_q.o_sh) && $stable(s_q.o_cur)
		&& $stable(s_q.o_bus) && $stable(s_q.o_pow))
		else $error("outputs changed outside cycle end");
	cal_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
		!s_q.cal_set |-> s_q.o_cur == 16'h0000 && s_q.o_pow == 16'h0000)
		else $error("current or power nonzero without calibration");
	single_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && bus_done && last && !mode[`SBM_CFG_CONT_BIT] && !cfg_wr
		|=> s_q.state == ST_IDLE && !adc_start
		##1 ($past(cfg_wr) || !adc_start))
		else $error("single shot did not stop");
	trigger_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && cfg_wr && !wr_pd && !old_pd |=> adc_start && s_q.pend == 1'b0)
		else $error("config write did not trigger");
	pd_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && cfg_wr && wr_pd |=> s_q.state == ST_IDLE && adc_power_down)
		else $error("power-down not entered");
	cont_next_a: assert property (@(posedge clock) disable iff (!rst_n)
		ce && bus_done && mode == `SBM_MODE_CONT && !cfg_wr
		|=> adc_start && !adc_sel_bus)
		else $error("continuous mode did not restart shunt");

endmodule
`default_nettype wire

/* tb/sbm_adc_model.sv */
// converter model answering start pulses after a set delay
`timescale 1ns/1ps
`default_nettype none

module sbm_adc_model (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// converter handshake
	input  wire logic        adc_start,
	input  wire logic        adc_sel_bus,
	output logic             adc_done,
	output logic [15:0]      adc_data,
	// samples and delay chosen by the bench
	input  wire logic [3:0]  dly,
	input  wire logic [15:0] sh_val,
	input  wire logic [15:0] bus_val
);
	logic [3:0]  cnt_q;
	logic        sel_q;
	logic [15:0] last_q;

	// a new start restarts a busy conversion, like the real converter
	always_ff @(posedge clock) begin
		adc_done <= 1'b0;
		// data line shows garbage outside the done cycle
		adc_data <= ~last_q;
		if (!rst_n) begin
			cnt_q  <= 4'h0;
			sel_q  <= 1'b0;
			last_q <= 16'h0;
		end else if (adc_start) begin
			cnt_q <= dly;
			sel_q <= adc_sel_bus;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				adc_done <= 1'b1;
				adc_data <= sel_q ? bus_val : sh_val;
				last_q   <= sel_q ? bus_val : sh_val;
			end
		end
	end
endmodule
`default_nettype wire

/* tb/test_shunt_bus_measure_sequencer_alert.sv */
// self-checking bench of the measurement sequencer and alert
`timescale 1ns/1ps
`default_nettype none

module test_shunt_bus_measure_sequencer_alert;
	logic        clock;
	logic        rst_n;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic        adc_start;
	logic        adc_sel_bus;
	logic        adc_power_down;
	logic        adc_done;
	logic [15:0] adc_data;
	logic        alert_oe;
	logic        alert_pin;
	logic        alert_lvl;
	logic        ce;
	logic [3:0]  dly;
	logic [15:0] sh_val;
	logic [15:0] bus_val;
	logic [15:0] v;
	logic [15:0] cal;
	logic        cal_set;
	logic        power_over_limit;
	logic [15:0] mk;
	logic [15:0] sv;
	logic [15:0] bv;
	int          failures;
	int          check_count;
	int          starts;
	int          cycles;
	int          base;
	int          seed;

	// open-drain pin with a pull-up
	assign alert_pin = alert_oe ? alert_lvl : 1'b1;

	sbm_top #(.RECOVER_CYCLES(19'h8)) DUT (
		.clock(clock), .rst_n(rst_n), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .adc_start(adc_start),
		.adc_sel_bus(adc_sel_bus), .adc_power_down(adc_power_down),
		.adc_done(adc_done), .adc_data(adc_data),
		.alert_in(alert_pin), .alert_out(alert_lvl), .alert_oe(alert_oe)
	);

	sbm_adc_model adc (
		.clock(clock), .rst_n(rst_n), .adc_start(adc_start),
		.adc_sel_bus(adc_sel_bus), .adc_done(adc_done),
		.adc_data(adc_data), .dly(dly), .sh_val(sh_val),
		.bus_val(bus_val)
	);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// start counter and hang guard
	always @(posedge clock) begin
		cycles++;
		if (adc_start === 1'b1) starts++;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end

	task complete_run;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(16'(reg_rvalid), 16'h1);
		v = reg_rdata;
	endtask

	// reads keep running while the converter works
	task shot(input logic [15:0] cfg, input int n);
		int s0;
		s0 = starts;
		wr(8'h00, cfg);
		repeat (50) rd(8'h04);
		chk(16'(starts - s0), 16'(n));
	endtask

	function automatic logic [15:0] exp_cur(input logic [15:0] s,
		input logic [15:0] c, input logic set);
		longint p;
		if (!set) return 16'h0;
		p = longint'($signed(s)) * longint'(c);
		p = p >>> 11;
		return p[15:0];
	endfunction

	function automatic logic [15:0] exp_pow(input logic [15:0] c,
		input logic [15:0] b);
		longint a;
		a = longint'($signed(c));
		if (a < 0) begin
			a = -a;
		end
		a = a * longint'(b) / 20000;
		return (a > 65535) ? 16'hffff : a[15:0];
	endfunction

	initial begin
		seed = $urandom(32'h0f49);
		rst_n = 1'b0;
		ce = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		dly = 4'h3;
		sh_val = 16'h1000;
		bus_val = 16'h1000;
		cal = 16'h0000;
		cal_set = 1'b0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rd(8'h00);
		chk(v, 16'h0007);
		rd(8'h06);
		chk(v, 16'h0000);
		rd(8'h0a);
		chk(v, 16'h0000);
		wr(8'h00, 16'h0003);
		repeat (100) @(posedge clock);
		for (int i = 0; i < 6; i++) begin
			sh_val <= 16'($urandom);
			bus_val <= 16'($urandom);
			dly <= 4'(2 + $urandom % 6);
			if (i == 3) begin
				cal = 16'($urandom) & 16'h7fff;
				cal_set = 1'b1;
				wr(8'h05, cal);
			end
			shot(16'h0003, 2);
			rd(8'h01);
			chk(v, sh_val);
			rd(8'h02);
			chk(v, bus_val);
			rd(8'h04);
			chk(v, exp_cur(sh_val, cal, cal_set));
			rd(8'h03);
			chk(v, exp_pow(exp_cur(sh_val, cal, cal_set), bus_val));
		end
		for (int m = 1; m < 4; m++) begin
			shot(16'(m), (m == 3) ? 2 : 1);
			shot(16'(m), (m == 3) ? 2 : 1);
		end
		rd(8'h06);
		chk(16'(v[3]), 16'h1);
		rd(8'h06);
		chk(16'(v[3]), 16'h0);
		shot(16'h0003, 2);
		shot(16'h0000, 0);
		chk(16'(adc_power_down), 16'h1);
		rd(8'h06);
		chk(16'(v[3]), 16'h1);
		wr(8'h07, 16'h5a5a);
		rd(8'h07);
		chk(v, 16'h5a5a);
		// a write while frozen must not land
		ce <= 1'b0;
		wr(8'h07, 16'h1234);
		ce <= 1'b1;
		rd(8'h07);
		chk(v, 16'h5a5a);
		dly <= 4'h2;
		shot(16'h0203, 8);
		rd(8'h01);
		chk(v, sh_val);
		wr(8'h05, 16'h0800);
		wr(8'h07, 16'h1000);
		for (int f = 0; f < 5; f++) begin
			for (int ex = 0; ex < 2; ex++) begin
				power_over_limit = 1'($urandom);
				mk = (16'h8000 >> f) | {14'h0, power_over_limit, 1'b1};
				if (f == 0 || f == 2) begin
					mk = mk | (16'h8000 >> (f + 1));
				end
				sv = 16'h1000;
				bv = 16'h1000;
				case (f)
				0: sv = ex ? 16'h1001 : 16'h0fff;
				1: sv = ex ? 16'h0fff : 16'h1001;
				2: bv = ex ? 16'h1001 : 16'h0fff;
				3: bv = ex ? 16'h0fff : 16'h1001;
				default: bv = ex ? 16'd25000 : 16'd15000;
				endcase
				sh_val <= sv;
				bus_val <= bv;
				wr(8'h06, mk);
				shot(16'h0003, 2);
				chk(16'(alert_oe), 16'(ex) ^ 16'(power_over_limit));
				chk(16'(alert_pin), 16'(ex == power_over_limit));
				rd(8'h06);
				chk(16'(v[4]), 16'(ex));
				chk(16'(v[3]), 16'h1);
				rd(8'h06);
				chk(16'(v[4]), 16'h0);
				@(posedge clock);
				#1;
				chk(16'(alert_oe), 16'(power_over_limit));
			end
		end
		// ready flag alone drives the pin
		wr(8'h06, 16'h0400);
		shot(16'h0003, 2);
		chk(16'(alert_oe), 16'h1);
		rd(8'h06);
		@(posedge clock);
		#1;
		chk(16'(alert_oe), 16'h0);
		// unlatched shunt over limit in continuous shunt-only mode
		wr(8'h06, 16'h8000);
		sh_val <= 16'h1001;
		wr(8'h00, 16'h0005);
		repeat (20) @(posedge clock);
		#1;
		chk(16'(alert_oe), 16'h1);
		sh_val <= 16'h0fff;
		repeat (20) @(posedge clock);
		#1;
		chk(16'(alert_oe), 16'h0);
		base = starts;
		wr(8'h00, 16'h0007);
		repeat (150) @(posedge clock);
		chk(16'((starts - base) > 10), 16'h1);
		complete_run();
	end
endmodule
`default_nettype wire
